/* pkg/sffr_pkg.sv */
// Purpose: shared constants and types for the fast-read sequencer
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   timing figures are in clock cycles
package sffr_pkg;

  localparam int ADDR_W         = 24;
  localparam int DATA_W         = 8;
  // cycles between consecutive bytes
  localparam int BYTE_CYCLES    = 8;
  // cycles a normal read needs before its first byte
  localparam int NORMAL_LAT     = 8;
  // fast read adds eight cycles to the first byte
  localparam int FAST_EXTRA     = 8;
  localparam int FIRST_LAT      = NORMAL_LAT + FAST_EXTRA;
  localparam int CNT_W          = 5;
  localparam int FIFO_DEPTH     = 8;
  // 1 selects the fast-read flavour, 0 blocks every request (no normal read exists)
  localparam bit FAST_FLAVOUR   = 1'b1;

  localparam logic [ADDR_W-1:0] ADDR_ONE  = 24'h000001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 5'h01;

  typedef enum logic [1:0] {
    SFFR_IDLE  = 2'b00,
    SFFR_FIRST = 2'b01,
    SFFR_NEXT  = 2'b10,
    SFFR_LAST  = 2'b11
  } sffr_state_e;

  // one byte together with the flash location it came from
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sffr_beat_s;

  localparam int BEAT_W = ADDR_W + DATA_W;

endpackage : sffr_pkg

/* verilog/sffr_top.sv */
// Purpose: fast-read command path streaming flash bytes to user logic
// Assumes: flash bytes arrive on a beat stream from the serial engine
//          the stream may stall; a due byte slot then waits for its beat
// Notes:   beats pass through an 8-word FIFO before the output stage
//          stream ready is a flop fed from a fill count kept beside the FIFO
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sffr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  // pointers carry one extra bit so that full and empty differ

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_r;
  logic [PW:0]      rd_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (wr_r - rd_r) != (PW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem[rd_r[PW-1:0]];

  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
    end
  end

  // storage has no reset; only words between the pointers are ever read
  always_ff @(posedge clk) begin
    if (push) mem[wr_r[PW-1:0]] <= in_data;
  end
endmodule : sffr_fifo

////////////////////////////////////////////////////////////////////////////////
module sffr_top
  import sffr_pkg::*;
#(
  parameter bit ECHO_EN = 1'b1,
  parameter int DEPTH   = FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              fast_read_req,
  input  wire logic              read_cont_en,
  input  wire logic [ADDR_W-1:0] start_addr,
  // flash byte stream from the serial engine
  input  wire logic [DATA_W-1:0] flash_byte,
  input  wire logic              flash_byte_valid,
  output logic                   flash_byte_ready,
  output logic                   busy,
  output logic      [DATA_W-1:0] byte_out,
  output logic                   byte_valid,
  output logic      [ADDR_W-1:0] addr_echo
);

  //////////////////////////////////////////////////////////////////////////////
  sffr_state_e       state_r;
  sffr_state_e       state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [ADDR_W-1:0] in_addr_r;
  logic              more_r;
  sffr_beat_s        in_beat;
  sffr_beat_s        out_beat;
  localparam int FW = $clog2(DEPTH) + 1;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              more_nxt;
  logic              push;
  logic [FW-1:0]     fill_r;
  logic [FW-1:0]     fill_nxt;
  logic              ready_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // flavour fixed at build time; only fast read exists here
  wire flavour_ok = FAST_FLAVOUR;

  // requests count only from idle, so a request while busy is dropped
  wire start  = (state_r == SFFR_IDLE) && fast_read_req && flavour_ok;
  wire active = state_r != SFFR_IDLE;
  wire due    = active && (cnt_r == CNT_ONE);
  // a due slot with no byte yet waits: the counter holds at one
  wire emit   = due && fifo_out_valid;
  wire final_byte = emit && (state_r == SFFR_LAST || !more_r);

  assign fifo_pop = emit;
  assign in_beat  = '{addr: in_addr_r, data: flash_byte};
  // a beat is taken whenever the registered ready meets a valid byte
  assign push      = flash_byte_valid && flash_byte_ready;
  // fill level after this edge; a start empties the FIFO
  assign fill_nxt  = start ? '0 : fill_r + FW'(push) - FW'(emit);
  // ready is a flop, so it must already know whether room remains next cycle
  assign ready_nxt = (state_nxt != SFFR_IDLE) && (fill_nxt != FW'(DEPTH));

  //////////////////////////////////////////////////////////////////////////////
  // slot counter: load on start or byte, hold at one while a slot waits
  assign cnt_nxt  = start ? CNT_W'(FIRST_LAT) :
                    emit  ? CNT_W'(BYTE_CYCLES) :
                    (active && cnt_r != CNT_ONE) ? cnt_r - CNT_ONE : cnt_r;
  // continue-enable seen low once ends the run after the next byte
  assign more_nxt = start  ? read_cont_en :
                    active ? more_r && read_cont_en : more_r;

  // stream beats queue here until their byte slot comes due
  sffr_fifo #(
    .WIDTH (BEAT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (start),
    .in_data   (in_beat),
    .in_valid  (push),
    .in_ready  (),
    .out_data  (out_beat),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: first slot, later slots, closing slot
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SFFR_IDLE: begin
        if (start) state_nxt = SFFR_FIRST;
      end
      SFFR_FIRST: begin
        if (final_byte) state_nxt = SFFR_IDLE;
        else if (emit) state_nxt = SFFR_NEXT;
      end
      SFFR_NEXT: begin
        if (final_byte) state_nxt = SFFR_IDLE;
        else if (!more_r) state_nxt = SFFR_LAST;
      end
      SFFR_LAST: begin
        if (final_byte) state_nxt = SFFR_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= SFFR_IDLE;
      cnt_r   <= CNT_ZERO;
      more_r  <= 1'b0;
      fill_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      more_r  <= more_nxt;
      fill_r  <= fill_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // location of the next beat taken from the stream
  always_ff @(posedge clk) begin
    if (sys_rst)
      in_addr_r <= ADDR_ZERO;
    else if (start)
      in_addr_r <= start_addr;
    else if (flash_byte_valid && flash_byte_ready)
      in_addr_r <= in_addr_r + ADDR_ONE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // output stage: every port here is a flop; byte and echo hold between bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy       <= 1'b0;
      flash_byte_ready <= 1'b0;
      byte_valid <= 1'b0;
      byte_out   <= DATA_ZERO;
      addr_echo  <= ADDR_ZERO;
    end else begin
      busy       <= (state_nxt != SFFR_IDLE);
      flash_byte_ready <= ready_nxt;
      byte_valid <= emit;
      if (emit) begin
        byte_out  <= out_beat.data;
        addr_echo <= ECHO_EN ? out_beat.addr : ADDR_ZERO;
      end
    end
  end

endmodule : sffr_top
`default_nettype wire

/* testbench/sffr_src.sv */
// Purpose: flash byte source facing the sequencer
// Assumes: restart marks a taken request
// Notes:   slow mode offers one byte per 16 cycles
`timescale 1ns/1ps
`default_nettype none
module sffr_src import sffr_pkg::*; (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              restart,
  input  wire logic              slow,
  output logic      [DATA_W-1:0] flash_byte,
  output logic                   flash_byte_valid,
  input  wire logic              flash_byte_ready
);
  logic [7:0] n_r;
  logic [3:0] ph_r;
  assign flash_byte_valid = !slow || ph_r == 4'h0;
  // idle data inverted so a stale byte never matches
  assign flash_byte = n_r ^ 8'h5A ^ {8{!flash_byte_valid}};
  always_ff @(posedge clk) begin
    ph_r <= sys_rst ? 4'h0 : ph_r + 4'h1;
    n_r <= (sys_rst || restart) ? 8'h00 : n_r + 8'(flash_byte_valid && flash_byte_ready);
  end
endmodule : sffr_src
`default_nettype wire

/* testbench/sffr_top_monitor.sv */
// Purpose: port checks for the fast-read sequencer
// Assumes: bound into sffr_top
// Notes:   one clock domain
`timescale 1ns/1ps
`default_nettype none
module sffr_top_monitor import sffr_pkg::*; #(parameter bit ECHO_EN = 1'b1) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              fast_read_req,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic              flash_byte_ready,
  input wire logic              busy,
  input wire logic [DATA_W-1:0] byte_out,
  input wire logic              byte_valid,
  input wire logic [ADDR_W-1:0] addr_echo
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [ADDR_W-1:0] exp_r;
  wire  [ADDR_W-1:0] exp_nxt = (fast_read_req && !busy) ? start_addr : byte_valid ? exp_r + ADDR_ONE : exp_r;
  always_ff @(posedge clk) exp_r <= exp_nxt;
  AST_BUSY_RISE: assert property (!busy && fast_read_req |=> busy) else $error("no busy");
  AST_FIRST_LAT: assert property ($rose(busy) |-> (!byte_valid)[*8] ##1 (!byte_valid)[*7])
    else $error("early byte");
  AST_SPACING: assert property (byte_valid |=> (!byte_valid)[*7]) else $error("close bytes");
  AST_VALID_CAUSE: assert property (byte_valid |-> $past(busy)) else $error("idle byte");
  AST_HOLD: assert property (!byte_valid && !$past(sys_rst) |-> $stable(byte_out))
    else $error("byte moved");
  AST_ECHO_HOLD: assert property (!byte_valid && !$past(sys_rst) |-> $stable(addr_echo))
    else $error("echo moved");
  AST_ECHO_STEP: assert property (byte_valid && ECHO_EN |-> addr_echo == exp_r) else $error("echo");
  AST_BUSY_END: assert property ($fell(busy) && !$past(sys_rst) |-> byte_valid) else $error("end");
  AST_READY_BUSY: assert property (flash_byte_ready |-> busy) else $error("ready idle");
  cover property ($fell(busy));
  cover property (byte_valid && busy);
  cover property (busy && !flash_byte_ready);
endmodule : sffr_top_monitor
bind sffr_top sffr_top_monitor #(.ECHO_EN(ECHO_EN)) sffr_top_monitor_i (.clk(clk), .sys_rst(sys_rst),
  .fast_read_req(fast_read_req), .start_addr(start_addr), .flash_byte_ready(flash_byte_ready),
  .busy(busy), .byte_out(byte_out), .byte_valid(byte_valid), .addr_echo(addr_echo));
`default_nettype wire

/* testbench/test_sffr_top.sv */
// Purpose: self-checking bench for the fast-read sequencer
// Assumes: 10 MHz clock, inputs moved 1 ns after each rising edge
// Notes:   bytes come from sffr_src
`timescale 1ns/1ps
`default_nettype none
module test_sffr_top import sffr_pkg::*;;
  logic              clk = 1'b0, sys_rst = 1'b1, fast_read_req = 1'b0, read_cont_en = 1'b0, slow = 1'b0;
  logic [ADDR_W-1:0] start_addr = ADDR_ZERO, addr_echo;
  logic [DATA_W-1:0] flash_byte, byte_out;
  logic              flash_byte_valid, flash_byte_ready, busy, byte_valid;
  int                err_total = 0, checks_done = 0;
  wire               restart = fast_read_req && !busy;
  always #50 clk = ~clk;
  sffr_top sffr_top_i (.clk(clk), .sys_rst(sys_rst), .fast_read_req(fast_read_req), .read_cont_en(read_cont_en),
    .start_addr(start_addr), .flash_byte(flash_byte), .flash_byte_valid(flash_byte_valid),
    .flash_byte_ready(flash_byte_ready), .busy(busy), .byte_out(byte_out), .byte_valid(byte_valid),
    .addr_echo(addr_echo));
  sffr_src sffr_src_i (.clk(clk), .sys_rst(sys_rst), .restart(restart), .slow(slow), .flash_byte(flash_byte),
    .flash_byte_valid(flash_byte_valid), .flash_byte_ready(flash_byte_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [ADDR_W-1:0] a, input int n, input logic s);
    int t, k, tl;
    t = 0;
    k = 0;
    tl = 0;
    slow = s;
    start_addr = a;
    read_cont_en = n > 1;
    fast_read_req = 1'b1;
    @(posedge clk) #1 fast_read_req = 1'b0;
    while (k < n && t < 600) begin
      @(posedge clk) #1 t++;
      fast_read_req = t == 20;
      if (t == 14 && !s) chk(flash_byte_ready, 0);
      if (byte_valid === 1'b1) begin
        if (!s) chk(t - tl, k ? 8 : 16);
        chk(byte_out, 8'(k) ^ 8'h5A);
        chk(addr_echo, 24'(a + 24'(k)));
        chk(busy, k < n - 1);
        tl = t;
        k++;
        if (k == n - 1) read_cont_en = 1'b0;
      end
    end
    chk(k, n);
    repeat (5) @(posedge clk);
    #1 chk(byte_out, 8'(n - 1) ^ 8'h5A);
    chk(busy, 0);
  endtask : rd
  task automatic sc_multi(); rd(24'h00FFFD, 6, 1'b0); endtask : sc_multi
  task automatic sc_single(); rd(24'h123456, 1, 1'b0); endtask : sc_single
  task automatic sc_slow(); rd(24'hFFFFFE, 4, 1'b1); endtask : sc_slow
  task automatic sc_reset();
    start_addr = 24'h0ABCDE;
    read_cont_en = 1'b1;
    fast_read_req = 1'b1;
    @(posedge clk) #1 fast_read_req = 1'b0;
    repeat (19) @(posedge clk);
    #1 chk(byte_out, 8'h5A);
    chk(addr_echo, 24'h0ABCDE);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(busy, 0);
    chk(byte_out, 0);
    chk(addr_echo, 0);
    chk(byte_valid, 0);
    chk(flash_byte_ready, 0);
    sys_rst = 1'b0;
    read_cont_en = 1'b0;
  endtask : sc_reset
  initial begin
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    sc_multi();
    sc_single();
    sc_reset();
    sc_slow();
    wrap_up();
  end
  initial begin
    #300000;
    err_total++;
    wrap_up();
  end
endmodule : test_sffr_top
`default_nettype wire
